//--- hw/lrs_pkg.sv
/*
 * Shared constants for the line resistor and detector status bank:
 * register addresses, field positions, reset values, timing counts and
 * the state type of the single-ended-one qualifier.
 * Assumes a 50 MHz system clock and an 8-bit register port fed by the
 * serial host engine.
 */
package lrs_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register addresses
   localparam logic [7:0] ADDR_RES_SET = 8'h06;
   localparam logic [7:0] ADDR_RES_CLR = 8'h07;
   localparam logic [7:0] ADDR_DET_STAT = 8'h08;
   localparam logic [7:0] ADDR_TMR_SET = 8'h18;
   localparam logic [7:0] ADDR_TMR_CLR = 8'h19;

   ////////////////////////////////////////////////////////////////////////////
   // resistor control fields
   localparam int RES_CHARGE = 7;
   localparam int RES_BLEED = 6;
   localparam int RES_RSVD = 5;
   localparam int RES_ID_GROUNDED_FLAG = 4;
   localparam int RES_DM_LOW = 3;
   localparam int RES_DP_LOW = 2;
   localparam int RES_DP_WEAK = 1;
   localparam int RES_DP_HIGH = 0;
   localparam logic [7:0] RES_RESET = 8'h03;
   localparam logic [7:0] RES_WMASK = 8'hDF;

   ////////////////////////////////////////////////////////////////////////////
   // timer control fields
   localparam int SE1_WAIT_FIELD_LSB = 4;
   localparam int SE1_WAIT_FIELD_W = 4;
   localparam logic [7:0] TMR_RESET = 8'h10;
   localparam logic [7:0] TMR_WMASK = 8'hF0;

   ////////////////////////////////////////////////////////////////////////////
   // detector status fields
   localparam int DET_CARKIT = 7;
   localparam int DET_RSVD = 6;
   localparam int DET_ID_OPEN = 5;
   localparam int DET_SE1 = 4;
   localparam int DET_ID_GROUNDED_FLAG = 3;
   localparam int DET_DP_RX = 2;
   localparam int DET_SESS = 1;
   localparam int DET_VBUS_HI = 0;
   localparam logic [7:0] DET_RESET = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // synchroniser lanes
   localparam int SYN_W = 7;
   localparam int SYN_CARKIT = 0;
   localparam int SYN_ID_OPEN = 1;
   localparam int SYN_ID_GROUNDED_FLAG = 2;
   localparam int SYN_DP_RX = 3;
   localparam int SYN_DM_RX = 4;
   localparam int SYN_SESS = 5;
   localparam int SYN_VBUS_HI = 6;

   ////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int SE1_STEP_US = 1000;
   localparam int SE1_STEP_CYCLES = SE1_STEP_US * 1000 / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      SE1_IDLE,
      SE1_TIMING,
      SE1_SEEN
   } lrs_se1_st_t;

endpackage

//--- hw/lrs_det_if.sv
/*
 * Carries the qualified detector levels from the synchroniser to the
 * register bank.
 * Assumes both ends run on the same system clock.
 */
interface lrs_det_if;
   import lrs_pkg::*;
   logic [SYN_W-1:0] level;
   modport src (output level);
   modport dst (input level);
endinterface

//--- hw/lrs_sync.sv
/*
 * Three-stage synchroniser for the analog detector outputs.
 * Assumes the raw levels are asynchronous to clk_i; a new level is
 * accepted once the second and third stages agree.
 */
module lrs_sync
   import lrs_pkg::*;
#(
   parameter int W = SYN_W
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // raw detector levels
   input wire logic [W-1:0] raw_i,
   // qualified levels
   lrs_det_if.src det
);

   logic [W-1:0] meta;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;
   logic [W-1:0] level;
   logic [W-1:0] next_level;

   ////////////////////////////////////////////////////////////////////////////
   // RULE19 agree then accept
   // meta feeds stage2 only, never the compare
   always_comb begin
      next_level = (~(stage2 ^ stage3) & stage3) | ((stage2 ^ stage3) & level);
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         meta <= '0;
         stage2 <= '0;
         stage3 <= '0;
         level <= '0;
      end else begin
         meta <= raw_i;
         stage2 <= meta;
         stage3 <= stage2;
         level <= next_level;
      end
   end

   assign det.level = level;

endmodule

//--- hw/lrs_regs.sv
/*
 * Resistor control, timer control and live detector status registers
 * of the USB line interface, with the single-ended-one qualifier.
 * Assumes a serial host engine presents decoded 8-bit register accesses
 * on clk_i, and the analog detectors drive raw asynchronous levels.
 */
// Functional notes
// RULE1 - bit 7 of resistor control connects the VBUS charging pull-up
// RULE2 - bit 6 of resistor control connects the VBUS discharge pull-down
// RULE3 - bit 5 of resistor control is reserved and always reads 0
// RULE4 - bit 4 of resistor control ties the ID pin to ground
// RULE5 - bit 3 of resistor control connects the DM pull-down
// RULE6 - bit 2 of resistor control connects the DP pull-down
// RULE7 - bit 1 of resistor control connects the DP weak pull-up
// RULE8 - bit 0 connects DP pull-up only while session valid is seen
// RULE9 - address 08h reads live detector levels, reset 0, bit 6 reserved
// RULE10 - status bit 7 follows the carkit DP threshold comparator
// RULE11 - status bit 5 is high while ID pin floats
// RULE12 - status bit 4 high after SE1 held for the programmed period
// RULE13 - status bit 3 is high while ID pin is grounded
// RULE14 - status bit 2 follows the DP single-ended receiver
// RULE15 - status bit 1 follows the session valid comparator
// RULE16 - status bit 0 follows the VBUS high comparator
// RULE17 - write ones at 06h to set, at 07h to clear; both read back
// RULE18 - SE1 period is timer bits 7..4 in 1 ms steps, default 1 ms
// RULE19 - every detector passes a multi-stage synchroniser before status
module lrs_regs
   import lrs_pkg::*;
#(
   parameter int unsigned STEP_CYCLES = SE1_STEP_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // register port from the serial host engine
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // raw analog detector levels
   input wire logic carkit_dplus_raw_i,
   input wire logic id_open_raw_i,
   input wire logic id_grounded_raw_i,
   input wire logic dplus_se_rx_raw_i,
   input wire logic dminus_se_rx_raw_i,
   input wire logic session_ok_raw_i,
   input wire logic vbus_high_raw_i,
   // resistor and switch controls
   output logic vbus_charge_sel_o,
   output logic vbus_bleed_sel_o,
   output logic id_ground_sw_o,
   output logic dminus_low_res_en_o,
   output logic dplus_low_res_en_o,
   output logic dplus_weak_high_en_o,
   output logic dplus_high_res_en_o
);

   localparam int CW = $clog2(STEP_CYCLES + 1);

   ////////////////////////////////////////////////////////////////////////////
   // set/clear update shared by both writable registers
   function automatic logic [7:0] set_clr(input logic [7:0] cur, input logic [7:0] wd,
                                          input logic [7:0] mask, input logic do_set,
                                          input logic do_clr);
      logic [7:0] res;
      res = cur;
      if (do_set) begin
         res = cur | (wd & mask);
      end else if (do_clr) begin
         res = cur & ~(wd & mask);
      end
      return res & mask;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // detector synchronisers
   lrs_det_if det_bus ();
   logic [SYN_W-1:0] raw_lvl;

   assign raw_lvl[SYN_CARKIT] = carkit_dplus_raw_i;
   assign raw_lvl[SYN_ID_OPEN] = id_open_raw_i;
   assign raw_lvl[SYN_ID_GROUNDED_FLAG] = id_grounded_raw_i;
   assign raw_lvl[SYN_DP_RX] = dplus_se_rx_raw_i;
   assign raw_lvl[SYN_DM_RX] = dminus_se_rx_raw_i;
   assign raw_lvl[SYN_SESS] = session_ok_raw_i;
   assign raw_lvl[SYN_VBUS_HI] = vbus_high_raw_i;

   // RULE19 synchronise all detectors
   lrs_sync #(
      .W(SYN_W)
   ) u_sync (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .raw_i(raw_lvl),
      .det(det_bus)
   );

   logic [SYN_W-1:0] lvl;
   assign lvl = det_bus.level;

   ////////////////////////////////////////////////////////////////////////////
   // control registers
   logic [7:0] res_ctrl;
   logic [7:0] next_res_ctrl;
   logic [7:0] tmr_ctrl;
   logic [7:0] next_tmr_ctrl;
   logic [SE1_WAIT_FIELD_W-1:0] se1_wait_field;

   always_comb begin
      // RULE17 set and clear addresses
      // RULE3 reserved bit masked off
      next_res_ctrl = set_clr(res_ctrl, reg_wdata_i, RES_WMASK,
                              reg_wr_i && (reg_addr_i == ADDR_RES_SET),
                              reg_wr_i && (reg_addr_i == ADDR_RES_CLR));
      next_tmr_ctrl = set_clr(tmr_ctrl, reg_wdata_i, TMR_WMASK,
                              reg_wr_i && (reg_addr_i == ADDR_TMR_SET),
                              reg_wr_i && (reg_addr_i == ADDR_TMR_CLR));
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         res_ctrl <= RES_RESET;
         tmr_ctrl <= TMR_RESET;
      end else begin
         res_ctrl <= next_res_ctrl;
         tmr_ctrl <= next_tmr_ctrl;
      end
   end

   // RULE18 period field, 1 ms per step
   assign se1_wait_field = tmr_ctrl[SE1_WAIT_FIELD_LSB +: SE1_WAIT_FIELD_W];

   ////////////////////////////////////////////////////////////////////////////
   // single-ended-one qualifier
   lrs_se1_st_t se1_st;
   lrs_se1_st_t next_se1_st;
   logic [CW-1:0] step_cnt;
   logic [CW-1:0] next_step_cnt;
   logic [SE1_WAIT_FIELD_W-1:0] ms_cnt;
   logic [SE1_WAIT_FIELD_W-1:0] next_ms_cnt;
   logic se1_line;
   logic step_wrap;

   assign se1_line = lvl[SYN_DP_RX] & lvl[SYN_DM_RX];
   assign step_wrap = (step_cnt == CW'(STEP_CYCLES - 1));

   // RULE12 continuous SE1 qualification
   // a field of zero qualifies at once; a field lowered mid-count is honoured
   always_comb begin
      next_se1_st = se1_st;
      next_step_cnt = step_cnt;
      next_ms_cnt = ms_cnt;
      case (se1_st)
         SE1_IDLE: begin
            next_step_cnt = '0;
            next_ms_cnt = '0;
            if (se1_line) begin
               next_se1_st = (se1_wait_field == '0) ? SE1_SEEN : SE1_TIMING;
            end
         end
         SE1_TIMING: begin
            if (!se1_line) begin
               next_se1_st = SE1_IDLE;
            end else if (step_wrap) begin
               next_step_cnt = '0;
               // RULE18 count whole 1 ms steps
               if ({1'b0, ms_cnt} + 5'h01 >= {1'b0, se1_wait_field}) begin
                  next_se1_st = SE1_SEEN;
               end else begin
                  next_ms_cnt = ms_cnt + 4'h1;
               end
            end else begin
               next_step_cnt = step_cnt + CW'(1);
            end
         end
         SE1_SEEN: begin
            if (!se1_line) begin
               next_se1_st = SE1_IDLE;
            end
         end
         default: begin
            next_se1_st = SE1_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         se1_st <= SE1_IDLE;
         step_cnt <= '0;
         ms_cnt <= '0;
      end else begin
         se1_st <= next_se1_st;
         step_cnt <= next_step_cnt;
         ms_cnt <= next_ms_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // live status, read data and pin drive
   logic [7:0] det_stat;
   logic [7:0] next_rdata;
   logic next_dp_high;

   always_comb begin
      // RULE9 live unlatched levels, bit 6 reserved
      det_stat = DET_RESET;
      // RULE10 carkit comparator
      det_stat[DET_CARKIT] = lvl[SYN_CARKIT];
      // RULE11 id floating
      det_stat[DET_ID_OPEN] = lvl[SYN_ID_OPEN];
      // RULE12 qualified SE1
      det_stat[DET_SE1] = (se1_st == SE1_SEEN);
      // RULE13 id grounded
      det_stat[DET_ID_GROUNDED_FLAG] = lvl[SYN_ID_GROUNDED_FLAG];
      // RULE14 DP receiver
      det_stat[DET_DP_RX] = lvl[SYN_DP_RX];
      // RULE15 session valid
      det_stat[DET_SESS] = lvl[SYN_SESS];
      // RULE16 vbus high
      det_stat[DET_VBUS_HI] = lvl[SYN_VBUS_HI];
   end

   always_comb begin
      // RULE17 both addresses read back
      if ((reg_addr_i == ADDR_RES_SET) || (reg_addr_i == ADDR_RES_CLR)) begin
         next_rdata = res_ctrl;
      end else if (reg_addr_i == ADDR_DET_STAT) begin
         next_rdata = det_stat;
      end else if ((reg_addr_i == ADDR_TMR_SET) || (reg_addr_i == ADDR_TMR_CLR)) begin
         next_rdata = tmr_ctrl;
      end else begin
         next_rdata = 8'h00;
      end
   end

   // RULE8 pull-up gated by session valid
   assign next_dp_high = res_ctrl[RES_DP_HIGH] & lvl[SYN_SESS];

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         reg_rdata_o <= 8'h00;
         vbus_charge_sel_o <= 1'b0;
         vbus_bleed_sel_o <= 1'b0;
         id_ground_sw_o <= 1'b0;
         dminus_low_res_en_o <= 1'b0;
         dplus_low_res_en_o <= 1'b0;
         dplus_weak_high_en_o <= 1'b0;
         dplus_high_res_en_o <= 1'b0;
      end else begin
         reg_rdata_o <= next_rdata;
         // RULE1 charge resistor
         vbus_charge_sel_o <= res_ctrl[RES_CHARGE];
         // RULE2 discharge resistor
         vbus_bleed_sel_o <= res_ctrl[RES_BLEED];
         // RULE4 id ground switch
         id_ground_sw_o <= res_ctrl[RES_ID_GROUNDED_FLAG];
         // RULE5 DM pull-down
         dminus_low_res_en_o <= res_ctrl[RES_DM_LOW];
         // RULE6 DP pull-down
         dplus_low_res_en_o <= res_ctrl[RES_DP_LOW];
         // RULE7 DP weak pull-up
         dplus_weak_high_en_o <= res_ctrl[RES_DP_WEAK];
         dplus_high_res_en_o <= next_dp_high;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   int unsigned se1_hold;

   always_ff @(posedge clk_i) begin
      if (srst_i || !se1_line) begin
         se1_hold <= 0;
      end else if (se1_hold != 32'hFFFF_FFFF) begin
         se1_hold <= se1_hold + 1;
      end
   end

   a_res_set_bits: assert property ( // RULE17
      @(posedge clk_i) disable iff (srst_i)
      (reg_wr_i && reg_addr_i == ADDR_RES_SET)
      |=> ((res_ctrl & $past(reg_wdata_i) & RES_WMASK) == ($past(reg_wdata_i) & RES_WMASK)))
      else $error("resistor set write did not set bits");

   a_res_clr_bits: assert property ( // RULE17
      @(posedge clk_i) disable iff (srst_i)
      (reg_wr_i && reg_addr_i == ADDR_RES_CLR) |=> ((res_ctrl & $past(reg_wdata_i)) == 8'h00))
      else $error("resistor clear write left bits set");

   a_res_rsvd_zero: assert property ( // RULE3
      @(posedge clk_i) disable iff (srst_i)
      (reg_addr_i == ADDR_RES_SET) |=> (reg_rdata_o[RES_RSVD] == 1'b0))
      else $error("reserved resistor bit read as one");

   a_charge_follows: assert property ( // RULE1
      @(posedge clk_i) disable iff (srst_i)
      (reg_wr_i && reg_addr_i == ADDR_RES_SET && reg_wdata_i[RES_CHARGE])
      |-> ##2 vbus_charge_sel_o)
      else $error("charge resistor not connected two cycles after set");

   a_pullup_needs_sess: assert property ( // RULE8
      @(posedge clk_i) disable iff (srst_i)
      dplus_high_res_en_o |-> ($past(lvl[SYN_SESS]) && $past(res_ctrl[RES_DP_HIGH])))
      else $error("DP pull-up connected without session valid");

   a_stat_read_live: assert property ( // RULE9
      @(posedge clk_i) disable iff (srst_i)
      (reg_addr_i == ADDR_DET_STAT)
      |=> (reg_rdata_o == {$past(lvl[SYN_CARKIT]), 1'b0, $past(lvl[SYN_ID_OPEN]),
                           $past(se1_st == SE1_SEEN), $past(lvl[SYN_ID_GROUNDED_FLAG]),
                           $past(lvl[SYN_DP_RX]), $past(lvl[SYN_SESS]),
                           $past(lvl[SYN_VBUS_HI])}))
      else $error("status read does not match live detector levels");

   a_se1_min_hold: assert property ( // RULE18
      @(posedge clk_i) disable iff (srst_i)
      $rose(se1_st == SE1_SEEN)
      |-> ($past(se1_hold) + 1 >= se1_wait_field * STEP_CYCLES))
      else $error("SE1 qualified before the programmed period");

   a_se1_drop_fast: assert property ( // RULE12
      @(posedge clk_i) disable iff (srst_i)
      !se1_line |=> (se1_st == SE1_IDLE))
      else $error("SE1 status held after lines left SE1");

   a_se1_max_wait: assert property ( // RULE12
      @(posedge clk_i) disable iff (srst_i)
      (se1_line && se1_wait_field == 4'h0 && se1_st == SE1_IDLE) |=> (se1_st == SE1_SEEN))
      else $error("zero SE1 period did not qualify at once");

   a_unmapped_zero: assert property ( // RULE9
      @(posedge clk_i) disable iff (srst_i)
      (reg_addr_i == 8'h00) |=> (reg_rdata_o == 8'h00))
      else $error("unmapped address read non-zero");

endmodule

//--- sim/lrs_line_model.sv
/*
 * Far-side model of the cable lines and carkit accessory: turns the
 * wanted detector levels into raw asynchronous comparator outputs.
 * Assumes the bench hands it the wanted levels and a lag in cycles.
 */
module lrs_line_model
   import lrs_pkg::*;
(
   // clock
   input wire logic clk_i,
   // wanted levels and lag
   input wire logic [SYN_W-1:0] want_i,
   input wire logic [3:0] lag_i,
   // raw comparator outputs
   output logic [SYN_W-1:0] raw_o
);
   timeunit 1ns;
   timeprecision 1ps;

   ////////////////////////////////////////////////////////////////////////////
   // edges off the clock
   // levels move mid-cycle so the synchroniser sees truly skewed edges
   // one process owns raw_o; the latest wanted level is taken after the lag
   initial begin
      raw_o = '0;
      forever begin
         @(want_i);
         repeat (lag_i) @(posedge clk_i);
         #7 raw_o = want_i;
      end
   end
endmodule

//--- sim/line_resistor_and_status_regs_test.sv
/*
 * Self-checking bench for the resistor control and detector status bank.
 * Assumes the line model drives the detectors and a shortened step count.
 */
module line_resistor_and_status_regs_test
   import lrs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int STEP = 10;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [7:0] reg_addr_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic [7:0] reg_rdata_o;
   logic [SYN_W-1:0] raw;
   logic [SYN_W-1:0] want = '0;
   logic [3:0] lag = 4'h0;
   logic [7:0] outs;
   int fails = 0;
   int num_checks = 0;

   initial forever #10 clk_i = ~clk_i;

   lrs_line_model lrs_line_model_inst (.clk_i(clk_i), .want_i(want), .lag_i(lag), .raw_o(raw));

   lrs_regs #(.STEP_CYCLES(STEP)) lrs_regs_inst (
      .clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
      .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .carkit_dplus_raw_i(raw[SYN_CARKIT]), .id_open_raw_i(raw[SYN_ID_OPEN]),
      .id_grounded_raw_i(raw[SYN_ID_GROUNDED_FLAG]), .dplus_se_rx_raw_i(raw[SYN_DP_RX]),
      .dminus_se_rx_raw_i(raw[SYN_DM_RX]), .session_ok_raw_i(raw[SYN_SESS]),
      .vbus_high_raw_i(raw[SYN_VBUS_HI]), .vbus_charge_sel_o(outs[7]),
      .vbus_bleed_sel_o(outs[6]), .id_ground_sw_o(outs[4]), .dminus_low_res_en_o(outs[3]),
      .dplus_low_res_en_o(outs[2]), .dplus_weak_high_en_o(outs[1]),
      .dplus_high_res_en_o(outs[0]));
   assign outs[5] = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   function automatic logic [7:0] exp_stat(input logic [SYN_W-1:0] v);
      return {v[SYN_CARKIT], 1'b0, v[SYN_ID_OPEN], v[SYN_DP_RX] & v[SYN_DM_RX],
              v[SYN_ID_GROUNDED_FLAG], v[SYN_DP_RX], v[SYN_SESS], v[SYN_VBUS_HI]};
   endfunction

   function automatic logic [7:0] exp_out(input logic [7:0] r, input logic s);
      return {r[7:6], 1'b0, r[4:1], r[0] & s};
   endfunction

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      @(posedge clk_i);
      #1 d = reg_rdata_o;
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // watchdog: the tests take about 1360 cycles
   initial begin
      repeat (8000) @(posedge clk_i);
      fails++;
      test_done();
   end

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      logic [31:0] seed;
      logic [7:0] d;
      logic [7:0] a;
      logic [7:0] res;
      int n;
      seed = 32'hEB7A6E2C;
      repeat (5) @(posedge clk_i);
      srst_i <= 1'b0;
      rd(ADDR_RES_CLR, d);
      chk("res reset", d, 8'h03);
      rd(ADDR_DET_STAT, d);
      chk("status reset", d, 8'h00);
      rd(ADDR_TMR_SET, d);
      chk("timer reset", d, 8'h10);
      chk("outputs reset", outs, 8'h02);
      wr(ADDR_RES_SET, 8'hFF);
      rd(ADDR_RES_SET, d);
      chk("res all set", d, 8'hDF);
      wr(ADDR_RES_CLR, 8'hFF);
      rd(ADDR_RES_SET, d);
      chk("res all clear", d, 8'h00);
      rd(8'h09, d);
      chk("unmapped read", d, 8'h00);
      $display("test reset and corners done");

      res = 8'h00;
      for (int i = 0; i < 40; i++) begin
         seed = lfsr(seed);
         want <= seed[22:16];
         lag <= {2'b00, seed[24:23]};
         a = seed[8] ? ADDR_RES_CLR : ADDR_RES_SET;
         if (seed[11:9] == 3'h0) begin
            a = 8'h05;
         end
         wr(a, seed[7:0]);
         if (a == ADDR_RES_SET) begin
            res = res | (seed[7:0] & 8'hDF);
         end else if (a == ADDR_RES_CLR) begin
            res = res & ~seed[7:0];
         end
         repeat (25) @(posedge clk_i);
         rd(seed[12] ? ADDR_RES_SET : ADDR_RES_CLR, d);
         chk("res ctrl", d, res);
         chk("res outputs", outs, exp_out(res, want[SYN_SESS]));
         rd(ADDR_DET_STAT, d);
         chk("status", d, exp_stat(want));
      end
      $display("test random set clear and detectors done");

      wr(ADDR_TMR_CLR, 8'hF0);
      wr(ADDR_TMR_SET, 8'h3F);
      rd(ADDR_TMR_SET, d);
      chk("timer field", d, 8'h30);
      lag <= 4'h0;
      want <= '0;
      rd(ADDR_DET_STAT, d);
      repeat (20) @(posedge clk_i);
      want <= 7'h18;
      n = 0;
      do begin
         @(posedge clk_i);
         #1 n++;
      end while (reg_rdata_o[DET_SE1] !== 1'b1 && n < 200);
      chk("se1 delay", 8'(n >= 3 * STEP && n <= 3 * STEP + 10), 8'h01);
      want <= 7'h08;
      repeat (10) @(posedge clk_i);
      rd(ADDR_DET_STAT, d);
      chk("se1 drop", d, 8'h04);
      // zero period: qualifies long before three steps could pass
      wr(ADDR_TMR_CLR, 8'hF0);
      want <= 7'h18;
      repeat (8) @(posedge clk_i);
      rd(ADDR_DET_STAT, d);
      chk("se1 zero period", d, exp_stat(7'h18));
      $display("test se1 qualification done");

      wr(ADDR_RES_SET, 8'hD0);
      @(posedge clk_i);
      srst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      srst_i <= 1'b0;
      #1 chk("outputs in reset", outs, 8'h00);
      rd(ADDR_RES_SET, d);
      chk("res after reset", d, 8'h03);
      rd(ADDR_TMR_CLR, d);
      chk("timer after reset", d, 8'h10);
      $display("test mid-run reset done");
      test_done();
   end
endmodule
